// ===== shared/adc_engine_pkg.sv
package adc_engine_pkg;
   // register offsets on the serial register port
   localparam logic [7:0] BIAS_OFS = 8'h60;
   localparam logic [7:0] SETUP_OFS = 8'h61;
   localparam logic [7:0] GAP_OFS = 8'h62;
   localparam logic [7:0] RESULT_HI_OFS = 8'h63;
   localparam logic [7:0] RESULT_LO_OFS = 8'h64;
   localparam logic [7:0] STATUS_OFS = 8'h9a;

   // reset values
   localparam logic [7:0] BIAS_RST = 8'h00;
   localparam logic [7:0] SETUP_RST = 8'h00;
   localparam logic [7:0] GAP_RST = 8'h00;

   // conversion_setup fields
   localparam int GO_BIT = 7;
   localparam int REPEAT_BIT = 6;
   localparam int COUNT_LSB = 4;
   localparam int CHAN_LSB = 0;

   // sample_gap_config fields
   localparam int ENG_RST_BIT = 7;
   localparam int AUTO_REF_BIT = 5;
   localparam int REF_EN_BIT = 4;
   localparam int GAP_CODE_LSB = 0;

   // conversion_event_status fields
   localparam int ST_EOC_BIT = 0;
   localparam int ST_LIMIT_BIT = 1;
   localparam int ST_REF_BIT = 2;

   // input selector
   localparam int CHAN_COUNT = 11;
   localparam logic [3:0] GROUND_CODE = 4'hb;

   // sample counts per count code
   localparam logic [6:0] COUNT_CODE0 = 7'h01;
   localparam logic [6:0] COUNT_CODE1 = 7'h10;
   localparam logic [6:0] COUNT_CODE2 = 7'h20;
   localparam logic [6:0] COUNT_CODE3 = 7'h40;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int GAP_BASE_NS = 62500;
   localparam int GAP_BASE_CYCLES = GAP_BASE_NS / CLK_PERIOD_NS;
endpackage : adc_engine_pkg

// ===== hw/adc_timing_engine.sv
`timescale 1ns/1ps
// Notes on behaviour
// - registers reached only through serial register port
// - one converter shared through eleven-input selector
// - pin bias forced off while reference disabled
// - two-bit bias code per pin, 0/3/10/50 uA
// - single, fixed-count and continuous engine modes
// - samples summed in accumulator, latest only if continuous; copied to results
// - end-of-conversion request raised after each cycle that engine reset does not cut off
// - writing start bit one while idle begins a cycle once reference on
// - busy while running; status register refused then
// - clearing start mid-cycle still finishes sample count
// - setup holds start, repeat, count, channel fields
// - codes 0-10 select inputs, 11-15 ground
// - repeat with count 00 converts back to back
// - fixed mode takes exactly 1/16/32/64 samples
// - multi-sample spacing set by wait code
// - wait code zero none, else doubling from base
// - engine reset returns idle, cleared at next start
// - reference off when auto and manual bits zero
module adc_timing_engine
   import adc_engine_pkg::*;
#(
   parameter int SAMPLE_W = 10,
   parameter int ACC_W = 16,
   parameter int GAP_BASE_CYC = GAP_BASE_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_refused,
   input wire logic i_sar_done,
   input wire logic [SAMPLE_W-1:0] i_sar_data,
   input wire logic [SAMPLE_W-1:0] i_limit_high,
   input wire logic [SAMPLE_W-1:0] i_limit_low,
   output logic o_sar_start,
   output logic o_ref_enable,
   output logic [CHAN_COUNT:0] o_mux_sel,
   output logic [5:0] o_bias_code,
   output logic o_busy,
   output logic o_eoc_req
);

   typedef enum logic [1:0] {S_IDLE, S_CONV, S_GAP, S_FIN} state_e;

   function automatic logic [CHAN_COUNT:0] chan_decode(input logic [3:0] code);
      logic [CHAN_COUNT:0] sel;
      sel = '0;
      if (code < GROUND_CODE) begin
         sel[code] = 1'b1;
      end else begin
         sel[CHAN_COUNT] = 1'b1;
      end
      return sel;
   endfunction : chan_decode
   function automatic logic [6:0] count_of(input logic [1:0] code);
      logic [6:0] n;
      case (code)
         2'h0: n = COUNT_CODE0;
         2'h1: n = COUNT_CODE1;
         2'h2: n = COUNT_CODE2;
         default: n = COUNT_CODE3;
      endcase
      return n;
   endfunction : count_of
   function automatic logic [31:0] gap_cycles(input logic [3:0] code);
      logic [31:0] n;
      n = '0;
      if (code != 4'h0) begin
         n = 32'(GAP_BASE_CYC) << (code - 4'h1);
      end
      return n;
   endfunction : gap_cycles
   logic [7:0] bias_q, setup_q, gap_cfg_q, rdata_q;
   state_e state_q;
   logic [1:0] cnt_code_q;
   logic [6:0] left_q;
   logic [31:0] timer_q, gap_len;
   logic [ACC_W-1:0] acc_q, result_q;
   logic refused_q, pend_q, cont_q, viol_end_q, sar_start_q, eoc_q, st_eoc_q, st_limit_q;
   logic wr_setup, wr_gap, abort_w, ref_on, go, begin_w, sample_done, viol_w, last_w, status_clr;

   // the serial interface is the only way in; no other port writes these
   assign wr_setup = i_reg_wr && (i_reg_addr == SETUP_OFS);
   assign wr_gap = i_reg_wr && (i_reg_addr == GAP_OFS);
   assign abort_w = wr_gap && i_reg_wdata[ENG_RST_BIT];
   assign ref_on = gap_cfg_q[AUTO_REF_BIT] || gap_cfg_q[REF_EN_BIT];
   assign go = setup_q[GO_BIT];
   assign begin_w = (state_q == S_IDLE) && pend_q && go && ref_on && !abort_w;
   assign sample_done = (state_q == S_CONV) && i_sar_done;
   assign viol_w = cont_q && ((i_sar_data > i_limit_high) || (i_sar_data < i_limit_low));
   // continuous runs on while repeat and start stay set and no limit is crossed; fixed counts down regardless of start
   assign last_w = cont_q ? !(setup_q[REPEAT_BIT] && go && !viol_w) : (left_q == 7'h00);
   assign gap_len = gap_cycles(gap_cfg_q[GAP_CODE_LSB +: 4]);
   assign status_clr = i_reg_rd && (i_reg_addr == STATUS_OFS) && (state_q == S_IDLE);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         bias_q <= BIAS_RST;
      end else if (i_clk_en && i_reg_wr && (i_reg_addr == BIAS_OFS)) begin
         bias_q <= i_reg_wdata;
      end
   end

   // host write wins over the hardware clear of the start bit
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         setup_q <= SETUP_RST;
      end else if (i_clk_en) begin
         if (wr_setup) begin
            setup_q <= i_reg_wdata;
         end else if (state_q == S_FIN && viol_end_q) begin
            setup_q[GO_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         gap_cfg_q <= GAP_RST;
      end else if (i_clk_en) begin
         if (wr_gap) begin
            gap_cfg_q <= i_reg_wdata;
         end else if (begin_w) begin
            gap_cfg_q[ENG_RST_BIT] <= 1'b0;
         end
      end
   end

   // a start is armed only by writing the start bit while idle
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pend_q <= 1'b0;
      end else if (i_clk_en) begin
         if (abort_w || begin_w) begin
            pend_q <= 1'b0;
         end else if (wr_setup && i_reg_wdata[GO_BIT] && state_q == S_IDLE) begin
            pend_q <= 1'b1;
         end else if (!go) begin
            pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q <= S_IDLE;
      end else if (i_clk_en) begin
         if (abort_w) begin
            state_q <= S_IDLE;
         end else begin
            case (state_q)
               S_IDLE: begin
                  if (begin_w) begin
                     state_q <= S_CONV;
                  end
               end
               S_CONV: begin
                  if (sample_done) begin
                     if (last_w) begin
                        state_q <= S_FIN;
                     end else if (!cont_q && gap_len != 32'h0) begin
                        state_q <= S_GAP;
                     end
                  end
               end
               S_GAP: begin
                  if (timer_q == 32'h1) begin
                     state_q <= S_CONV;
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // mode and count are latched so a mid-cycle setup write cannot cut the sum short
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cont_q <= 1'b0;
         cnt_code_q <= 2'h0;
         left_q <= 7'h00;
      end else if (i_clk_en) begin
         if (begin_w) begin
            cont_q <= setup_q[REPEAT_BIT] && (setup_q[COUNT_LSB +: 2] == 2'h0);
            cnt_code_q <= setup_q[COUNT_LSB +: 2];
            left_q <= count_of(setup_q[COUNT_LSB +: 2]) - 7'h01;
         end else if (sample_done && left_q != 7'h00) begin
            left_q <= left_q - 7'h01;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         timer_q <= 32'h0;
      end else if (i_clk_en) begin
         if (sample_done) begin
            timer_q <= gap_len;
         end else if (state_q == S_GAP && timer_q != 32'h0) begin
            timer_q <= timer_q - 32'h1;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sar_start_q <= 1'b0;
      end else if (i_clk_en) begin
         sar_start_q <= begin_w
            || (sample_done && !last_w && (cont_q || gap_len == 32'h0) && !abort_w)
            || (state_q == S_GAP && timer_q == 32'h1 && !abort_w);
      end
   end

   // continuous mode keeps only the latest single sample
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         acc_q <= '0;
         viol_end_q <= 1'b0;
      end else if (i_clk_en) begin
         if (begin_w) begin
            acc_q <= '0;
            viol_end_q <= 1'b0;
         end else if (sample_done) begin
            acc_q <= (cont_q ? '0 : acc_q) + ACC_W'(i_sar_data);
            viol_end_q <= viol_w;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         result_q <= '0;
         eoc_q <= 1'b0;
      end else if (i_clk_en) begin
         eoc_q <= (state_q == S_FIN);
         if (state_q == S_FIN) begin
            result_q <= acc_q;
         end
      end
   end

   // sticky status: a new event beats the clear-on-read in the same cycle
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_eoc_q <= 1'b0;
         st_limit_q <= 1'b0;
      end else if (i_clk_en) begin
         if (state_q == S_FIN) begin
            st_eoc_q <= 1'b1;
         end else if (status_clr) begin
            st_eoc_q <= 1'b0;
         end
         if (state_q == S_FIN && viol_end_q) begin
            st_limit_q <= 1'b1;
         end else if (status_clr) begin
            st_limit_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= 8'h00;
         refused_q <= 1'b0;
      end else if (i_clk_en) begin
         refused_q <= 1'b0;
         if (i_reg_rd) begin
            if (i_reg_addr == BIAS_OFS) begin
               rdata_q <= bias_q;
            end else if (i_reg_addr == SETUP_OFS) begin
               rdata_q <= setup_q;
            end else if (i_reg_addr == GAP_OFS) begin
               rdata_q <= gap_cfg_q;
            end else if (i_reg_addr == RESULT_HI_OFS) begin
               rdata_q <= result_q[15:8];
            end else if (i_reg_addr == RESULT_LO_OFS) begin
               rdata_q <= result_q[7:0];
            end else if (i_reg_addr == STATUS_OFS && state_q != S_IDLE) begin
               rdata_q <= 8'h00;
               refused_q <= 1'b1;
            end else if (i_reg_addr == STATUS_OFS) begin
               rdata_q <= {5'h00, ref_on, st_limit_q, st_eoc_q};
            end else begin
               rdata_q <= 8'h00;
            end
         end
      end
   end

   generate
      for (genvar p = 0; p < 3; p++) begin : g_bias
         assign o_bias_code[2*p +: 2] = ref_on ? bias_q[2*p +: 2] : 2'b00;
      end
   endgenerate

   assign o_mux_sel = chan_decode(setup_q[CHAN_LSB +: 4]);
   assign o_ref_enable = ref_on;
   assign o_busy = (state_q != S_IDLE);
   assign o_sar_start = sar_start_q;
   assign o_eoc_req = eoc_q;
   assign o_reg_rdata = rdata_q;
   assign o_reg_refused = refused_q;

   // helper: samples taken in the running cycle
   logic [7:0] taken_q;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         taken_q <= 8'h00;
      end else if (i_clk_en) begin
         if (begin_w) begin
            taken_q <= 8'h00;
         end else if (sample_done) begin
            taken_q <= taken_q + 8'h01;
         end
      end
   end
   sequence s_fixed_step;
      sample_done && !cont_q && !last_w && !abort_w && i_clk_en;
   endsequence
   sequence s_viol_hit;
      sample_done && viol_w && !abort_w && i_clk_en;
   endsequence
   bias_ref_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !ref_on |-> (o_bias_code == 6'h00)) else $error("bias on with reference off");
   start_begins_a: assert property (@(posedge i_clock) disable iff (i_rst)
      begin_w && i_clk_en |=> o_sar_start && o_busy) else $error("start did not begin cycle");
   ref_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
      state_q == S_IDLE && !ref_on && i_clk_en |=> !o_sar_start) else $error("conversion without reference");
   status_refuse_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_reg_rd && i_reg_addr == STATUS_OFS && o_busy && i_clk_en |=> o_reg_refused && o_reg_rdata == 8'h00)
      else $error("status read not refused while busy");
   keep_running_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s_fixed_step |=> o_busy) else $error("cycle ended before sample count");
   result_copy_a: assert property (@(posedge i_clock) disable iff (i_rst)
      state_q == S_FIN && i_clk_en |=> o_eoc_req && result_q == $past(acc_q)) else $error("result not copied");
   fixed_count_a: assert property (@(posedge i_clock) disable iff (i_rst)
      state_q == S_FIN && !cont_q |-> taken_q == {1'b0, count_of(cnt_code_q)}) else $error("wrong sample count");
   ground_sel_a: assert property (@(posedge i_clock) disable iff (i_rst)
      o_mux_sel[CHAN_COUNT] == (setup_q[CHAN_LSB +: 4] >= GROUND_CODE)) else $error("ground select wrong");
   back_to_back_a: assert property (@(posedge i_clock) disable iff (i_rst)
      sample_done && cont_q && !last_w && !abort_w && i_clk_en |=> o_sar_start) else $error("continuous gap");
   gap_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      state_q == S_GAP && timer_q > 32'h1 |=> !o_sar_start) else $error("sample started inside gap");
   gap_wait_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s_fixed_step ##0 (gap_len != 32'h0) |=> timer_q == $past(gap_len) && state_q == S_GAP)
      else $error("gap length wrong");
   viol_stop_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s_viol_hit ##1 i_clk_en && !wr_setup && !abort_w |-> ##1 !go && o_eoc_req) else $error("violation did not stop");
   eng_reset_a: assert property (@(posedge i_clock) disable iff (i_rst)
      abort_w && i_clk_en |=> !o_busy) else $error("engine reset ignored");

endmodule : adc_timing_engine

// ===== tb/sar_model.sv
`timescale 1ns/1ps
module sar_model #(
   parameter int W = 10
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [3:0] i_lat,
   input wire logic [W-1:0] i_value,
   input wire logic i_clr,
   output logic o_done,
   output logic [W-1:0] o_data,
   output logic [15:0] o_sum,
   output logic [W-1:0] o_last
);
   logic [3:0] cnt_q;
   logic run_q;
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 4'h0;
         run_q <= 1'b0;
         o_done <= 1'b0;
         o_data <= '0;
         o_sum <= 16'h0000;
         o_last <= '0;
      end else begin
         o_done <= 1'b0;
         // data line not held past the done pulse, so a stale sample cannot pass
         o_data <= ~o_data;
         if (i_clr) begin
            o_sum <= 16'h0000;
         end
         if (i_start) begin
            run_q <= 1'b1;
            cnt_q <= i_lat;
         end else if (run_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end else if (run_q) begin
            run_q <= 1'b0;
            o_done <= 1'b1;
            o_data <= i_value;
            o_sum <= o_sum + 16'(i_value);
            o_last <= i_value;
         end
      end
   end
endmodule : sar_model

// ===== tb/test_adc_timing_engine.sv
`timescale 1ns/1ps
module test_adc_timing_engine
   import adc_engine_pkg::*;
;
   logic i_clock, i_rst, i_clk_en, i_reg_wr, i_reg_rd, o_reg_refused, i_sar_done;
   logic o_sar_start, o_ref_enable, o_busy, o_eoc_req, p_clr, rf;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rv, bv, hi;
   logic [9:0] i_sar_data, i_limit_high, i_limit_low, p_value, p_last;
   logic [11:0] o_mux_sel;
   logic [5:0] o_bias_code;
   logic [15:0] p_sum;
   logic [3:0] p_lat;
   logic [31:0] rnd;
   int n_fail, cmp_count, n_start, n_eoc, t_now, t_last, gap_v, d0;
   // small gap base keeps the longest wait short in simulation
   localparam int GAP_BASE_TB = 2;

   adc_timing_engine #(.GAP_BASE_CYC(GAP_BASE_TB)) u_dut (
      .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr),
      .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
      .o_reg_refused(o_reg_refused), .i_sar_done(i_sar_done), .i_sar_data(i_sar_data),
      .i_limit_high(i_limit_high), .i_limit_low(i_limit_low), .o_sar_start(o_sar_start),
      .o_ref_enable(o_ref_enable), .o_mux_sel(o_mux_sel), .o_bias_code(o_bias_code),
      .o_busy(o_busy), .o_eoc_req(o_eoc_req));

   sar_model u_sar (.i_clock(i_clock), .i_rst(i_rst), .i_start(o_sar_start), .i_lat(p_lat),
      .i_value(p_value), .i_clr(p_clr), .o_done(i_sar_done), .o_data(i_sar_data), .o_sum(p_sum),
      .o_last(p_last));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // expected figures taken from the count and wait tables, not from the design
   function automatic int exp_count(input logic [1:0] code);
      int n;
      case (code)
         2'h0: n = 1;
         2'h1: n = 16;
         2'h2: n = 32;
         default: n = 64;
      endcase
      return n;
   endfunction : exp_count

   function automatic int exp_gap(input int code);
      return (code == 0) ? 0 : (GAP_BASE_TB << (code - 1));
   endfunction : exp_gap

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // pulse counters live on the rising edge so one-cycle pulses are never missed
   always @(posedge i_clock) begin
      rnd <= lfsr(rnd);
      t_now = t_now + 1;
      if (o_sar_start === 1'b1) begin
         n_start = n_start + 1;
         gap_v = t_now - t_last;
         t_last = t_now;
      end
      if (o_eoc_req === 1'b1) begin
         n_eoc = n_eoc + 1;
      end
   end

   always @(negedge i_clock) begin
      p_value <= rnd[9:0] | 10'h001;
   end

   task automatic final_report();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_cnt(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         n_fail++;
         $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clock);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_clock);
      i_reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(negedge i_clock);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_clock);
      i_reg_rd = 1'b0;
      rv = o_reg_rdata;
      rf = o_reg_refused;
   endtask : rd

   task automatic wait_eoc();
      for (int k = 0; k < 20000; k++) begin
         if (n_eoc != 0) begin
            return;
         end
         @(negedge i_clock);
      end
      chk_cnt(0, 1);
      final_report();
   endtask : wait_eoc

   task automatic chk_result(input logic [15:0] exp);
      rd(RESULT_HI_OFS);
      hi = rv;
      rd(RESULT_LO_OFS);
      chk({hi, rv}, exp);
   endtask : chk_result

   task automatic run_fixed(input logic [1:0] code, input logic [3:0] gap, input logic mid);
      wr(SETUP_OFS, {2'b00, code, 4'h3});
      wr(GAP_OFS, {4'h1, gap});
      p_clr = 1'b1;
      n_start = 0;
      n_eoc = 0;
      @(negedge i_clock);
      p_clr = 1'b0;
      wr(SETUP_OFS, {2'b10, code, 4'h3});
      repeat (3) @(negedge i_clock);
      if (mid) begin
         chk(o_busy, 1'b1);
         rd(STATUS_OFS);
         chk({rf, rv}, 9'h100);
         wr(SETUP_OFS, {2'b00, code, 4'h3});
      end
      wait_eoc();
      chk(o_busy, 1'b0);
      chk_cnt(n_start, exp_count(code));
      chk_result(p_sum);
      rd(STATUS_OFS);
      chk({rf, rv[ST_EOC_BIT]}, 2'b01);
   endtask : run_fixed

   initial begin
      rnd = 32'h45326b38;
      i_rst = 1'b1;
      i_clk_en = 1'b1;
      i_reg_addr = 8'h00;
      i_reg_wdata = 8'h00;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_limit_high = 10'h3ff;
      i_limit_low = 10'h000;
      p_lat = 4'h1;
      p_clr = 1'b0;
      repeat (6) @(negedge i_clock);
      i_rst = 1'b0;
      chk(o_mux_sel, 12'h001);
      rd(BIAS_OFS);
      chk(rv, BIAS_RST);
      rd(SETUP_OFS);
      chk(rv, SETUP_RST);
      rd(8'h70);
      chk(rv, 8'h00);
      bv = rnd[7:0];
      wr(BIAS_OFS, bv);
      chk({o_ref_enable, o_bias_code}, 7'h00);
      rd(BIAS_OFS);
      chk(rv, bv);
      for (int m = 1; m < 3; m++) begin
         wr(GAP_OFS, 8'(m << 4));
         chk({o_ref_enable, o_bias_code}, {1'b1, bv[5:0]});
      end
      for (int i = 0; i < 16; i++) begin
         wr(SETUP_OFS, 8'(i));
         chk(o_mux_sel, (i < CHAN_COUNT) ? (12'h001 << i) : 12'h800);
      end
      for (int c = 0; c < 4; c++) begin
         p_lat = rnd[3:0];
         run_fixed(2'(c), {3'b000, rnd[4]}, c > 0);
      end
      // fixed converter latency so only the gap setting moves the start spacing
      p_lat = 4'h2;
      run_fixed(2'b01, 4'h0, 1'b0);
      d0 = gap_v;
      for (int g = 1; g < 4; g++) begin
         run_fixed(2'b01, 4'(g), 1'b0);
         chk_cnt((gap_v - d0 - exp_gap(g)) inside {[0:2]}, 1);
      end
      p_lat = 4'h0;
      wr(SETUP_OFS, 8'h40);
      wr(GAP_OFS, 8'h13);
      n_start = 0;
      n_eoc = 0;
      wr(SETUP_OFS, 8'hc0);
      repeat (100) @(negedge i_clock);
      chk_cnt(gap_v <= 5 && n_start > 15, 1);
      chk(o_busy, 1'b1);
      wr(SETUP_OFS, 8'h80);
      wr(SETUP_OFS, 8'h00);
      wait_eoc();
      chk_result({6'h00, p_last});
      i_limit_high = 10'h000;
      wr(SETUP_OFS, 8'h40);
      n_start = 0;
      n_eoc = 0;
      wr(SETUP_OFS, 8'hc0);
      wait_eoc();
      chk_cnt(n_start, 1);
      rd(SETUP_OFS);
      chk(rv, 8'h40);
      rd(STATUS_OFS);
      chk(rv[ST_LIMIT_BIT:ST_EOC_BIT], 2'b11);
      chk_result({6'h00, p_last});
      i_limit_high = 10'h3ff;
      p_lat = 4'hf;
      wr(SETUP_OFS, 8'h30);
      wr(GAP_OFS, 8'h10);
      n_eoc = 0;
      wr(SETUP_OFS, 8'hb0);
      repeat (3) @(negedge i_clock);
      wr(GAP_OFS, 8'h90);
      repeat (2) @(negedge i_clock);
      chk(o_busy, 1'b0);
      chk_cnt(n_eoc, 0);
      rd(GAP_OFS);
      chk(rv, 8'h90);
      wr(SETUP_OFS, 8'h00);
      n_start = 0;
      wr(SETUP_OFS, 8'h80);
      wait_eoc();
      rd(GAP_OFS);
      chk(rv, 8'h10);
      chk_cnt(n_start, 1);
      // a write made while the enable is low must be lost
      i_clk_en = 1'b0;
      wr(BIAS_OFS, ~bv);
      i_clk_en = 1'b1;
      rd(BIAS_OFS);
      chk(rv, bv);
      final_report();
   end
endmodule : test_adc_timing_engine
